// ===== hw/spr_pkg.sv
package spr_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CFG = 8'h00;
  localparam logic [7:0] ADR_ID = 8'h01;
  localparam logic [7:0] ADR_GRADE = 8'h02;
  localparam logic [7:0] ADR_INDEX = 8'h05;
  localparam logic [7:0] ADR_PROG_LO = 8'h08;
  localparam logic [7:0] ADR_PROG_HI = 8'h25;
  localparam logic [7:0] ADR_MODES = 8'h08;
  localparam logic [7:0] ADR_CLOCK = 8'h09;
  localparam logic [7:0] ADR_FILTER = 8'h0f;
  localparam logic [7:0] ADR_OFFSET = 8'h10;
  localparam logic [7:0] ADR_GAIN = 8'h11;
  localparam logic [7:0] ADR_PHASE = 8'h16;
  localparam logic [7:0] ADR_XFER = 8'hff;
  localparam int NPROG = 30;

  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_FIXED = 8'h18;
  localparam logic [7:0] GRADE_RST = 8'h00;
  localparam logic [7:0] INDEX_RST = 8'h0f;
  localparam logic [7:0] CLOCK_RST = 8'h01;
  localparam logic [7:0] FILTER_RST = 8'h30;
  localparam logic [7:0] OFFSET_RST = 8'h20;
  localparam logic [7:0] GAIN_RST = 8'h01;
  localparam logic [7:0] PHASE_RST = 8'h03;
  localparam int CFG_LSB_HI = 6;
  localparam int CFG_LSB_LO = 1;
  localparam int CFG_SRST_HI = 5;
  localparam int CFG_SRST_LO = 2;
  localparam int XFER_BIT = 0;
  localparam int DCS_BIT = 0;
  localparam int INS_RW = 15;
  localparam logic [1:0] WL_STREAM = 2'h3;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef enum logic [1:0] {SPR_IDLE, SPR_INSTR, SPR_DATA} spr_phase_e;

  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] sdio_sync;
    logic [1:0] csn_sync;
    logic sclk_prev;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic strap_csn;
    logic strap_sclk;
    logic strap_sdio;
    spr_phase_e phase;
    logic [3:0] cnt;
    logic [15:0] sh;
    logic rw;
    logic [1:0] wlen;
    logic [12:0] addr;
    logic [1:0] left;
    logic [7:0] tx;
    logic sdo;
    logic oe;
    logic lsb_first;
    logic [7:0] index;
    logic [NPROG-1:0][7:0] stage;
    logic [NPROG-1:0][7:0] active;
    logic xfer;
    logic srst;
  } spr_state_s;

  function automatic logic [7:0] spr_prog_rst(input logic [7:0] a);
    case (a)
      ADR_CLOCK: return CLOCK_RST;
      ADR_FILTER: return FILTER_RST;
      ADR_OFFSET: return OFFSET_RST;
      ADR_GAIN: return GAIN_RST;
      ADR_PHASE: return PHASE_RST;
      default: return 8'h00;
    endcase
  endfunction : spr_prog_rst

  function automatic spr_state_s spr_rst_state();
    spr_state_s s;
    s = '0;
    s.csn_sync = 2'h3;
    s.phase = SPR_IDLE;
    s.index = INDEX_RST;
    for (int i = 0; i < NPROG; i++) begin
      s.stage[i] = spr_prog_rst(8'(i) + ADR_PROG_LO);
    end
    s.active = s.stage;
    return s;
  endfunction : spr_rst_state

  localparam spr_state_s ST_RST = spr_rst_state();

endpackage : spr_pkg

// ===== hw/spr_port.sv
// What this block does
// RULE1: select low plus clock rise starts frame
// RULE2: sixteen-bit instruction, then word-length bytes
// RULE3: word length 11 streams until select high
// RULE4: select high between bytes stalls, resumes
// RULE5: select high mid-byte resets the machine
// RULE6: clock and data decoded only while selected
// RULE7: select high at power-up means pin straps
// RULE8: select tied low gives 2-wire mode
// RULE9: 2-wire host avoids streaming transfers
// RULE10: instruction marks write or readback
// RULE11: readback turns data pin to output
// RULE12: MSB first default, LSB by config
// RULE13: data sampled on clock rise, select on every system clock
// RULE14: drive on falling edge, release on rising
// RULE15: program register writes take effect after transfer write
// RULE16: clock register resets 0x01, stabilizer on
// RULE17: three address groups decoded
// RULE18: host writes undefined addresses only defaults
// RULE19: host writes zero to reserved bits
// RULE20: port config mirrored nibbles, resets 0x18
// RULE21: transfer bit copies staged to active
// RULE22: instruction is rw, two length, address
// RULE23: address steps down MSB-first, up LSB-first
`timescale 1ns/1ps
module spr_port #(
  parameter logic [7:0] CHIP_ID = 8'h5a  // arbitrary value
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_sclk,
  input wire logic i_port_select_n,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  output logic o_lsb_first,
  output logic o_dcs_enable,
  output logic [2:0] o_power_mode,
  output logic [7:0] o_channel_index,
  output logic o_strap_mode,
  output logic o_strap_sclk,
  output logic o_strap_sdio
);

  spr_pkg::spr_state_s r;
  spr_pkg::spr_state_s next_r;
  logic rise;
  logic fall;
  logic csn;

  // ----------------------------------------------------------------
  // edges of the synchronised serial clock
  // ----------------------------------------------------------------
  // RULE13: rising edge sampling
  assign rise = r.sclk_sync[1] & ~r.sclk_prev;
  assign fall = ~r.sclk_sync[1] & r.sclk_prev;
  assign csn = r.csn_sync[1];

  // RULE17: address decode
  function automatic logic [7:0] rd(input logic [12:0] a);
    logic [7:0] v;
    logic l;
    l = r.lsb_first;
    v = 8'h00;
    // RULE20: mirrored readback
    if (a == 13'(spr_pkg::ADR_CFG)) begin
      v = spr_pkg::CFG_FIXED;
      v[spr_pkg::CFG_LSB_HI] = l;
      v[spr_pkg::CFG_LSB_LO] = l;
    end else if (a == 13'(spr_pkg::ADR_ID)) begin
      v = CHIP_ID;
    end else if (a == 13'(spr_pkg::ADR_GRADE)) begin
      v = spr_pkg::GRADE_RST;
    end else if (a == 13'(spr_pkg::ADR_INDEX)) begin
      v = r.index;
    end else if (a >= 13'(spr_pkg::ADR_PROG_LO) && a <= 13'(spr_pkg::ADR_PROG_HI)) begin
      v = r.stage[5'(a - 13'(spr_pkg::ADR_PROG_LO))];
    end
    return v;
  endfunction : rd

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic d;
    logic [15:0] sh16;
    logic [7:0] b;
    logic [12:0] nxa;
    logic wr_srst;
    next_r = r;
    d = r.sdio_sync[1];
    sh16 = 16'h0000;
    b = 8'h00;
    nxa = 13'h0000;
    wr_srst = 1'b0;
    if (i_ce) begin
      // pulses freeze with the rest while the enable is low
      next_r.xfer = 1'b0;
      next_r.srst = 1'b0;
      next_r.sclk_sync = {r.sclk_sync[0], i_sclk};
      next_r.sdio_sync = {r.sdio_sync[0], i_sdio};
      next_r.csn_sync = {r.csn_sync[0], i_port_select_n};
      next_r.sclk_prev = r.sclk_sync[1];
      // RULE7: strap capture after release
      if (!r.strap_done) begin
        next_r.strap_cnt = r.strap_cnt + 2'h1;
        if (r.strap_cnt == spr_pkg::STRAP_WAIT) begin
          next_r.strap_done = 1'b1;
          next_r.strap_csn = csn;
          next_r.strap_sclk = r.sclk_sync[1];
          next_r.strap_sdio = d;
        end
      end
      if (csn) begin
        // RULE6: select high gates the clock and data decode
        next_r.oe = 1'b0;
        // RULE5: mid-byte abort
        if ((r.phase == spr_pkg::SPR_INSTR && r.cnt[2:0] != 3'h0) ||
            (r.phase == spr_pkg::SPR_DATA && r.cnt != 4'h0)) begin
          next_r.phase = spr_pkg::SPR_IDLE;
        // RULE3: stream ends on select high
        end else if (r.phase == spr_pkg::SPR_DATA && r.wlen == spr_pkg::WL_STREAM) begin
          next_r.phase = spr_pkg::SPR_IDLE;
        end
        // RULE4: otherwise the frame simply waits
      end else if (rise) begin
        if (r.phase != spr_pkg::SPR_DATA) begin
          // RULE12: bit order of the shifter
          sh16 = r.lsb_first ? {d, r.sh[15:1]} : {r.sh[14:0], d};
          next_r.sh = sh16;
          next_r.phase = spr_pkg::SPR_INSTR;
          // RULE1: first rise after select low
          // RULE8: no select edge needed, so 2-wire works
          next_r.cnt = (r.phase == spr_pkg::SPR_IDLE) ? 4'h1 : r.cnt + 4'h1;
          // RULE2: sixteenth bit ends instruction
          if (r.phase == spr_pkg::SPR_INSTR && r.cnt == 4'hf) begin
            // RULE22: field layout
            // RULE10: read or write flag
            next_r.rw = sh16[spr_pkg::INS_RW];
            next_r.wlen = sh16[14:13];
            next_r.left = sh16[14:13];
            next_r.addr = sh16[12:0];
            next_r.cnt = 4'h0;
            next_r.phase = spr_pkg::SPR_DATA;
            next_r.tx = rd(sh16[12:0]);
          end
        end else begin
          b = r.lsb_first ? {d, r.sh[7:1]} : {r.sh[6:0], d};
          next_r.sh = {8'h00, b};
          next_r.cnt = r.cnt + 4'h1;
          if (r.cnt == 4'h7) begin
            next_r.cnt = 4'h0;
            // RULE23: address stepping
            nxa = r.lsb_first ? r.addr + 13'h1 : r.addr - 13'h1;
            next_r.addr = nxa;
            next_r.tx = rd(nxa);
            if (!r.rw) begin
              // RULE20: either nibble decodes
              if (r.addr == 13'(spr_pkg::ADR_CFG)) begin
                next_r.lsb_first = b[spr_pkg::CFG_LSB_HI] | b[spr_pkg::CFG_LSB_LO];
                wr_srst = b[spr_pkg::CFG_SRST_HI] | b[spr_pkg::CFG_SRST_LO];
              end else if (r.addr == 13'(spr_pkg::ADR_INDEX)) begin
                next_r.index = b;
              end else if (r.addr == 13'(spr_pkg::ADR_XFER)) begin
                // RULE15: commit only here
                // RULE21: staged to active copy
                if (b[spr_pkg::XFER_BIT]) begin
                  next_r.active = r.stage;
                  next_r.xfer = 1'b1;
                end
              end else if (r.addr >= 13'(spr_pkg::ADR_PROG_LO) &&
                           r.addr <= 13'(spr_pkg::ADR_PROG_HI)) begin
                next_r.stage[5'(r.addr - 13'(spr_pkg::ADR_PROG_LO))] = b;
              end
            end
            if (r.wlen != spr_pkg::WL_STREAM) begin
              if (r.left == 2'h0) begin
                // RULE14: release on a rising edge
                next_r.phase = spr_pkg::SPR_IDLE;
                next_r.oe = 1'b0;
              end else begin
                next_r.left = r.left - 2'h1;
              end
            end
          end
        end
      end else if (fall && r.phase == spr_pkg::SPR_DATA && r.rw) begin
        // RULE11: readback drives the pin
        // RULE14: turn on from a falling edge
        next_r.oe = 1'b1;
        next_r.sdo = r.lsb_first ? r.tx[0] : r.tx[7];
        next_r.tx = r.lsb_first ? {1'b0, r.tx[7:1]} : {r.tx[6:0], 1'b0};
      end
      // soft reset returns registers, not the synchronisers or straps
      if (wr_srst) begin
        next_r.srst = 1'b1;
        next_r.lsb_first = 1'b0;
        next_r.index = spr_pkg::INDEX_RST;
        next_r.stage = spr_pkg::ST_RST.stage;
        next_r.active = spr_pkg::ST_RST.active;
        next_r.phase = spr_pkg::SPR_IDLE;
        next_r.oe = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // RULE16: clock register reset value in ST_RST
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= spr_pkg::ST_RST;
    end else begin
      r <= next_r;
    end
  end

  assign o_sdio = r.sdo;
  assign o_sdio_oe = r.oe;
  assign o_lsb_first = r.lsb_first;
  // RULE16: stabilizer follows the active copy
  assign o_dcs_enable = r.active[spr_pkg::ADR_CLOCK - spr_pkg::ADR_PROG_LO][spr_pkg::DCS_BIT];
  assign o_power_mode = r.active[spr_pkg::ADR_MODES - spr_pkg::ADR_PROG_LO][2:0];
  assign o_channel_index = r.index;
  assign o_strap_mode = r.strap_done & r.strap_csn;
  assign o_strap_sclk = r.strap_sclk;
  assign o_strap_sdio = r.strap_sdio;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_frame_start;
    i_ce && !csn && rise && r.phase == spr_pkg::SPR_IDLE;
  endsequence
  sequence s_last_instr_bit;
    i_ce && !csn && rise && r.phase == spr_pkg::SPR_INSTR && r.cnt == 4'hf;
  endsequence
  sequence s_byte_end;
    i_ce && !csn && rise && r.phase == spr_pkg::SPR_DATA && r.cnt == 4'h7;
  endsequence

  property p_frame_start;
    s_frame_start |=> r.phase == spr_pkg::SPR_INSTR && r.cnt == 4'h1;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame did not start"); // RULE1

  property p_instr_len;
    s_last_instr_bit |=> r.phase == spr_pkg::SPR_DATA && r.cnt == 4'h0 && r.wlen == r.left;
  endproperty
  a_instr_len: assert property (p_instr_len) else $error("instruction not 16 bits"); // RULE2

  property p_stream_hold;
    s_byte_end ##0 (r.wlen == spr_pkg::WL_STREAM) |=> r.phase == spr_pkg::SPR_DATA || r.srst;
  endproperty
  a_stream_hold: assert property (p_stream_hold) else $error("stream ended early"); // RULE3

  property p_stall_hold;
    i_ce && csn && r.phase == spr_pkg::SPR_DATA && r.cnt == 4'h0 &&
      r.wlen != spr_pkg::WL_STREAM |=> r.phase == spr_pkg::SPR_DATA && $stable(r.addr);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall lost the frame"); // RULE4

  property p_midbyte_reset;
    i_ce && csn && r.phase == spr_pkg::SPR_INSTR && r.cnt[2:0] != 3'h0
      |=> r.phase == spr_pkg::SPR_IDLE;
  endproperty
  a_midbyte_reset: assert property (p_midbyte_reset) else $error("no mid-byte reset"); // RULE5

  property p_data_abort;
    i_ce && csn && r.phase == spr_pkg::SPR_DATA && r.cnt != 4'h0
      |=> r.phase == spr_pkg::SPR_IDLE;
  endproperty
  a_data_abort: assert property (p_data_abort) else $error("data byte not aborted"); // RULE5

  property p_idle_no_drive;
    i_ce && csn |=> !o_sdio_oe;
  endproperty
  a_idle_no_drive: assert property (p_idle_no_drive) else $error("driving while deselected"); // RULE6

  property p_oe_read_only;
    o_sdio_oe |-> r.rw;
  endproperty
  a_oe_read_only: assert property (p_oe_read_only) else $error("driving in a write"); // RULE11

  property p_oe_on_fall;
    $rose(o_sdio_oe) |-> $past(fall && i_ce);
  endproperty
  a_oe_on_fall: assert property (p_oe_on_fall) else $error("turn-on not at fall"); // RULE14

  property p_oe_release;
    s_byte_end ##0 (r.left == 2'h0 && r.wlen != spr_pkg::WL_STREAM) |=> !o_sdio_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("pin not released"); // RULE14

  property p_dcs_commit;
    $changed(o_dcs_enable) |-> r.xfer || r.srst;
  endproperty
  a_dcs_commit: assert property (p_dcs_commit) else $error("stabilizer changed uncommitted"); // RULE15

  property p_addr_step;
    // order as it stood during the byte; a config write may flip it at the end
    s_byte_end |=> r.srst || r.addr == ($past(r.lsb_first) ? $past(r.addr) + 13'h1 :
      $past(r.addr) - 13'h1);
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address did not step"); // RULE23

endmodule : spr_port

// ===== tb/spr_host.sv
`timescale 1ns/1ps
module spr_host (
  output logic o_sclk,
  output logic o_port_select_n,
  output logic o_pin,
  output logic o_drv,
  input wire logic i_dev_sdio,
  input wire logic i_dev_oe,
  input wire logic i_two_wire
);
  // ----------------------------------------------------------------
  // host side of the serial link
  // ----------------------------------------------------------------
  logic dq;
  // released line falls to the pull-down level
  assign o_pin = i_dev_oe ? i_dev_sdio : (o_drv ? dq : 1'b0);
  initial begin
    o_sclk = 1'b0;
    o_port_select_n = 1'b1;
    o_drv = 1'b1;
    dq = 1'b1;
  end
  task automatic bitx(input logic b, input logic rdb, output logic s, inout logic ok);
    o_drv = !rdb;
    dq = b;
    #260;
    o_sclk = 1'b1;
    s = o_pin;
    if (rdb && i_dev_oe !== 1'b1) ok = 1'b0;
    #140;
    o_sclk = 1'b0;
  endtask : bitx
  task automatic xfer(input logic rw, input logic [1:0] wl, input logic [12:0] adr,
                      input int nb, input int cut, input logic stl, input logic lsb,
                      input logic [23:0] wd, output logic [23:0] rd, output logic ok);
    logic [15:0] ins;
    logic s;
    ins = {rw, wl, adr};
    rd = '0;
    ok = 1'b1;
    o_port_select_n = 1'b0;
    #100;
    for (int i = 0; i < 16; i++) begin
      bitx(ins[lsb ? i : 15 - i], 1'b0, s, ok);
    end
    for (int k = 0; k < nb; k++) begin
      for (int j = 0; j < 8; j++) begin
        if (cut < 0 || 8 * k + j < cut) begin
          bitx(wd[8 * k + (lsb ? j : 7 - j)], rw, s, ok);
          rd[8 * k + (lsb ? j : 7 - j)] = s;
        end
      end
      if (stl && k < nb - 1) begin
        #260;
        o_port_select_n = 1'b1;
        #1000;
        o_port_select_n = 1'b0;
        #100;
      end
    end
    o_drv = 1'b0;
    #260;
    o_port_select_n = !i_two_wire;
    #1000;
  endtask : xfer
endmodule : spr_host

// ===== tb/tb_spr_port.sv
`timescale 1ns/1ps
module tb_spr_port;
  // ----------------------------------------------------------------
  // bench
  // ----------------------------------------------------------------
  localparam logic [7:0] ID = 8'h3c;  // arbitrary value
  logic i_clk_sys, i_arst_n, sclk, csn, pin, drv, dsd, doe, lsb, dcs, strap, s_sclk, s_sdio;
  logic [2:0] pmode;
  logic [7:0] idx;
  logic [23:0] rd;
  logic ok, two_wire;
  int mismatches, n_tests, cycles;
  spr_port #(.CHIP_ID(ID)) u_spr_port (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_ce(1'b1), .i_sclk(sclk), .i_port_select_n(csn), .i_sdio(pin), .o_sdio(dsd),
    .o_sdio_oe(doe), .o_lsb_first(lsb), .o_dcs_enable(dcs), .o_power_mode(pmode),
    .o_channel_index(idx), .o_strap_mode(strap), .o_strap_sclk(s_sclk),
    .o_strap_sdio(s_sdio));
  spr_host u_spr_host (.o_sclk(sclk), .o_port_select_n(csn), .o_pin(pin), .o_drv(drv),
    .i_dev_sdio(dsd), .i_dev_oe(doe), .i_two_wire(two_wire));
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  task automatic report_and_stop();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // both parties driving the pin is a fault
  always @(negedge i_clk_sys) if (drv === 1'b1 && doe !== 1'b0) chk(doe, 1'b0);
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    u_spr_host.xfer(1'b0, 2'h0, a, 1, -1, 1'b0, 1'b0, {16'h0, d}, rd, ok);
  endtask : wr
  task automatic rd1(input logic [12:0] a, input logic [7:0] e);
    u_spr_host.xfer(1'b1, 2'h0, a, 1, -1, 1'b0, 1'b0, 24'h0, rd, ok);
    chk(rd[7:0], e);
    chk(ok, 1'b1);
  endtask : rd1
  task automatic settle();
    repeat (10) @(negedge i_clk_sys);
  endtask : settle
  task automatic t_reset();
    chk(dcs, 1'b1);
    chk(pmode, 3'h0);
    chk(idx, 8'h0f);
    chk(lsb, 1'b0);
    chk({strap, s_sdio, s_sclk}, 3'b110);
    $display("done: reset values");
  endtask : t_reset
  task automatic t_regs();
    rd1(13'h000, 8'h18);
    rd1(13'h001, ID);
    rd1(13'h002, 8'h00);
    rd1(13'h009, 8'h01);
    rd1(13'h003, 8'h00);
    rd1(13'h0ff, 8'h00);
    $display("done: register reads");
  endtask : t_regs
  task automatic t_xfer();
    wr(13'h009, 8'h00);
    settle();
    chk(dcs, 1'b1);
    rd1(13'h009, 8'h00);
    wr(13'h0ff, 8'h01);
    settle();
    chk(dcs, 1'b0);
    $display("done: transfer");
  endtask : t_xfer
  task automatic t_stall();
    u_spr_host.xfer(1'b0, 2'h1, 13'h009, 2, -1, 1'b1, 1'b0, 24'h000501, rd, ok);
    wr(13'h0ff, 8'h01);
    settle();
    chk(dcs, 1'b1);
    chk(pmode, 3'h5);
    $display("done: stalled two-byte write");
  endtask : t_stall
  task automatic t_abort();
    u_spr_host.xfer(1'b0, 2'h0, 13'h008, 1, 4, 1'b0, 1'b0, 24'h000002, rd, ok);
    wr(13'h0ff, 8'h01);
    settle();
    chk(pmode, 3'h5);
    rd1(13'h008, 8'h05);
    $display("done: abort mid-byte");
  endtask : t_abort
  task automatic t_stream();
    u_spr_host.xfer(1'b1, 2'h3, 13'h001, 3, -1, 1'b0, 1'b0, 24'h0, rd, ok);
    chk(rd, {8'h00, 8'h18, ID});
    chk(ok, 1'b1);
    $display("done: streaming read");
  endtask : t_stream
  task automatic t_lsb();
    wr(13'h005, 8'h03);
    settle();
    chk(idx, 8'h03);
    wr(13'h000, 8'h5a);
    settle();
    chk(lsb, 1'b1);
    u_spr_host.xfer(1'b1, 2'h1, 13'h001, 2, -1, 1'b0, 1'b1, 24'h0, rd, ok);
    chk(rd[15:0], {8'h00, ID});
    chk(ok, 1'b1);
    u_spr_host.xfer(1'b0, 2'h0, 13'h000, 1, -1, 1'b0, 1'b1, 24'h00003c, rd, ok);
    settle();
    chk(lsb, 1'b0);
    chk(idx, 8'h0f);
    $display("done: lsb first and soft reset");
  endtask : t_lsb
  task automatic t_twowire();
    two_wire = 1'b1;
    wr(13'h005, 8'h21);
    settle();
    chk(idx, 8'h21);
    rd1(13'h005, 8'h21);
    two_wire = 1'b0;
    rd1(13'h009, 8'h01);
    $display("done: 2-wire mode");
  endtask : t_twowire
  initial begin
    i_arst_n = 1'b0;
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    two_wire = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    settle();
    t_reset();
    t_regs();
    t_xfer();
    t_stall();
    t_abort();
    t_stream();
    t_lsb();
    t_twowire();
    report_and_stop();
  end
endmodule : tb_spr_port
